// ==== core/wpf_filters.v ====
// receive wakeup filters: directed ipv4, directed ipv6, four flexible filters
`timescale 1ns/1ps
`include "wpf_map.vh"

module wpf_filters #(
    parameter NFLEX = 4,
    parameter NV4 = 4
) (
    input wire i_clk, // core clock
    input wire i_rst, // synchronous reset, active high
    input wire i_rx_valid, // received byte offered
    input wire [7:0] i_rx_data, // received byte
    input wire i_rx_last, // last byte of frame
    output wire o_rx_ready, // byte accepted when valid
    output wire o_st_valid, // storage byte offered
    output wire [7:0] o_st_data, // storage byte
    output wire o_st_last, // storage last byte
    output wire o_st_keep, // on last: keep this frame
    input wire i_st_ready, // storage takes byte
    input wire i_ipv4_en, // directed ipv4 filter enable
    input wire i_ipv6_en, // directed ipv6 filter enable
    input wire [NFLEX-1:0] i_flex_en, // flexible filter enables
    input wire i_power_event_enable, // arms the wake output
    input wire [47:0] i_station_mac, // station address, byte 0 in [47:40]
    input wire i_vlan_id_check, // compare vlan id
    input wire [11:0] i_vlan_id, // expected vlan id
    input wire [NV4*32-1:0] i_ipv4_addr_table, // entry i at [32i+:32], msb first
    input wire [127:0] i_ipv6_addr_table, // msb is first byte on wire
    input wire i_flex_wr, // write one flexible table byte
    input wire [1:0] i_flex_sel, // filter written
    input wire [6:0] i_flex_idx, // byte position written
    input wire i_flex_mask, // mask bit written
    input wire [7:0] i_flex_value, // value byte written
    input wire [NFLEX*8-1:0] i_flex_length_table, // minimum length per filter
    output reg o_wake, // one-cycle wakeup pulse
    output reg [NFLEX+1:0] o_wake_status // {flex, ipv6, ipv4} of last frame
);

    ////////////////////////////////////////////////////////////////
    // helpers
    // byte k of a word, k = 0 is the most significant byte
    function [7:0] pick_byte;
        input [127:0] word;
        input [3:0] k;
        input [4:0] nbytes;
        reg [4:0] idx;
        begin
            idx = nbytes - 5'd1 - {1'b0, k};
            pick_byte = word[{idx[3:0], 3'b000} +: 8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // stream handshake
    wire beat;
    wire buf_in_ready;
    wire frame_end;
    wire keep_now;
    wire [9:0] buf_out;
    assign o_rx_ready = buf_in_ready;
    assign beat = i_rx_valid & buf_in_ready;
    assign frame_end = beat & i_rx_last;
    // every accepted byte goes on to storage, verdict rides on the last one
    wpf_skid_buf #(
        .W(10)
    ) u_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(i_rx_valid),
        .i_in_data({keep_now & i_rx_last, i_rx_last, i_rx_data}),
        .o_in_ready(buf_in_ready),
        .o_out_valid(o_st_valid),
        .o_out_data(buf_out),
        .i_out_ready(i_st_ready)
    );
    assign o_st_data = buf_out[7:0];
    assign o_st_last = buf_out[8];
    assign o_st_keep = buf_out[9];

    ////////////////////////////////////////////////////////////////
    // header parser state
    reg [7:0] pos_q, pos_d;
    reg [7:0] prev_q, prev_d;
    reg [7:0] off_q, off_d;
    reg [7:0] base_q, base_d;
    reg [7:0] snap_base_q, snap_base_d;
    reg vlan_q, vlan_d;
    reg snap_q, snap_d;
    reg typ_done_q, typ_done_d;
    reg [15:0] etype_q, etype_d;
    reg mac_ok_q, mac_ok_d;
    reg hdr_ok_q, hdr_ok_d;
    reg ver4_q, ver4_d;
    reg ver6_q, ver6_d;
    reg v6m_q, v6m_d;
    reg v4_hit_q, v4_hit_d;
    reg v6_hit_q, v6_hit_d;
    reg [15:0] typ;
    reg [7:0] rel;
    reg [7:0] snap_rel;
    wire [NV4-1:0] v4m_d;
    wire [NFLEX-1:0] flex_hit_d;
    wire [47:0] snap_pat;
    wire [7:0] v4_rel;
    wire [7:0] v6_rel;
    assign snap_pat = `WPF_SNAP_PATTERN;
    assign v4_rel = rel - `WPF_V4_DIP_REL; // ipv4 address byte index
    assign v6_rel = rel - `WPF_V6_DIP_REL; // ipv6 address byte index
    // next state of the parser for the byte being taken
    always @* begin
        pos_d = pos_q;
        prev_d = prev_q;
        off_d = off_q;
        base_d = base_q;
        snap_base_d = snap_base_q;
        vlan_d = vlan_q;
        snap_d = snap_q;
        typ_done_d = typ_done_q;
        etype_d = etype_q;
        mac_ok_d = mac_ok_q;
        hdr_ok_d = hdr_ok_q;
        ver4_d = ver4_q;
        ver6_d = ver6_q;
        v6m_d = v6m_q;
        typ = {prev_q, i_rx_data};
        rel = pos_q - base_q;
        snap_rel = pos_q - snap_base_q;
        if (beat) begin
            prev_d = i_rx_data;
            if (pos_q != 8'hff) begin
                pos_d = pos_q + 8'd1;
            end
            // destination must be the station address
            if (pos_q < `WPF_MAC_BYTES &&
                    i_rx_data != pick_byte({80'h0, i_station_mac}, pos_q[3:0], 5'd6)) begin
                mac_ok_d = 1'b0;
            end
            // tag, length or real type in the two bytes ending here
            if (!typ_done_q && pos_q == `WPF_TYPE_LO_POS + off_q) begin
                if (typ == `WPF_TYPE_VLAN && !vlan_q && !snap_q) begin
                    vlan_d = 1'b1;
                    off_d = off_q + `WPF_VLAN_LEN;
                end else if (typ <= `WPF_TYPE_LEN_MAX && !snap_q) begin
                    snap_d = 1'b1;
                    snap_base_d = pos_q + 8'd1;
                    off_d = off_q + `WPF_SNAP_LEN;
                end else begin
                    typ_done_d = 1'b1;
                    etype_d = typ;
                    base_d = pos_q + 8'd1;
                end
            end
            // vlan identifier check
            if (vlan_q && pos_q == `WPF_VLAN_ID_LO_POS && i_vlan_id_check &&
                    {prev_q[3:0], i_rx_data} != i_vlan_id) begin
                hdr_ok_d = 1'b0;
            end
            // llc/snap constant bytes
            if (snap_q && pos_q >= snap_base_q && snap_rel < `WPF_SNAP_CHK_BYTES &&
                    i_rx_data != pick_byte({80'h0, snap_pat}, snap_rel[3:0], 5'd6)) begin
                hdr_ok_d = 1'b0;
            end
            // ip header fields, positions shifted by tag and snap
            if (typ_done_q) begin
                if (rel == `WPF_VER_REL) begin
                    ver4_d = (i_rx_data[7:4] == `WPF_VER_IPV4);
                    ver6_d = (i_rx_data[7:4] == `WPF_VER_IPV6);
                end
                if (rel >= `WPF_V6_DIP_REL && rel <= `WPF_V6_DIP_LAST &&
                        i_rx_data != pick_byte(i_ipv6_addr_table, v6_rel[3:0], 5'd16)) begin
                    v6m_d = 1'b0;
                end
            end
        end
    end
    // four ipv4 entries compared side by side
    genvar gi;
    generate
        for (gi = 0; gi < NV4; gi = gi + 1) begin : g_v4
            reg m_q;
            wire hit_byte;
            assign hit_byte = (i_rx_data == pick_byte({96'h0,
                i_ipv4_addr_table[gi*32 +: 32]}, v4_rel[3:0], 5'd4));
            assign v4m_d[gi] = m_q & ~(beat & typ_done_q & rel >= `WPF_V4_DIP_REL &
                rel <= `WPF_V4_DIP_LAST & ~hit_byte);
            // entry survives the frame while its bytes agree
            always @(posedge i_clk) begin
                if (i_rst || frame_end) begin
                    m_q <= 1'b1;
                end else begin
                    m_q <= v4m_d[gi];
                end
            end
        end
    endgenerate
    // directed ip verdicts once the last destination byte is in
    always @* begin
        v4_hit_d = v4_hit_q;
        v6_hit_d = v6_hit_q;
        if (beat && typ_done_q && rel == `WPF_V4_DIP_LAST) begin
            v4_hit_d = i_ipv4_en & mac_ok_d & hdr_ok_d & ver4_q &
                (etype_q == `WPF_TYPE_IPV4) & (|v4m_d);
        end
        if (beat && typ_done_q && rel == `WPF_V6_DIP_LAST) begin
            v6_hit_d = i_ipv6_en & mac_ok_d & hdr_ok_d & ver6_q &
                (etype_q == `WPF_TYPE_IPV6) & v6m_d;
        end
    end
    // parser registers, restarted after each frame
    always @(posedge i_clk) begin
        if (i_rst || frame_end) begin
            pos_q <= `WPF_POS_RST;
            prev_q <= 8'h00;
            off_q <= `WPF_OFF_RST;
            base_q <= 8'h00;
            snap_base_q <= 8'h00;
            vlan_q <= 1'b0;
            snap_q <= 1'b0;
            typ_done_q <= 1'b0;
            etype_q <= 16'h0000;
            mac_ok_q <= 1'b1;
            hdr_ok_q <= 1'b1;
            ver4_q <= 1'b0;
            ver6_q <= 1'b0;
            v6m_q <= 1'b1;
            v4_hit_q <= 1'b0;
            v6_hit_q <= 1'b0;
        end else begin
            pos_q <= pos_d;
            prev_q <= prev_d;
            off_q <= off_d;
            base_q <= base_d;
            snap_base_q <= snap_base_d;
            vlan_q <= vlan_d;
            snap_q <= snap_d;
            typ_done_q <= typ_done_d;
            etype_q <= etype_d;
            mac_ok_q <= mac_ok_d;
            hdr_ok_q <= hdr_ok_d;
            ver4_q <= ver4_d;
            ver6_q <= ver6_d;
            v6m_q <= v6m_d;
            v4_hit_q <= v4_hit_d;
            v6_hit_q <= v6_hit_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // flexible filters at fixed byte positions, no header skipping
    genvar gf;
    generate
        for (gf = 0; gf < NFLEX; gf = gf + 1) begin : g_flex
            reg [7:0] val_mem [0:127];
            reg [127:0] mask_q;
            reg fail_q;
            reg hit_q;
            wire wr;
            wire [7:0] len_raw;
            wire [7:0] len;
            wire in_win;
            wire bad;
            wire fail_d;
            assign wr = i_flex_wr & ({30'd0, i_flex_sel} == gf);
            assign len_raw = i_flex_length_table[gf*8 +: 8];
            assign len = (len_raw > `WPF_FLEX_BYTES) ? `WPF_FLEX_BYTES : len_raw;
            assign in_win = (pos_q < len);
            assign bad = in_win & mask_q[pos_q[6:0]] &
                (i_rx_data != val_mem[pos_q[6:0]]);
            assign fail_d = fail_q | (beat & bad);
            assign flex_hit_d[gf] = hit_q | (beat & i_flex_en[gf] & ~fail_d &
                (len != 8'h00) & (pos_q == len - 8'd1));
            // value table
            always @(posedge i_clk) begin
                if (wr) begin
                    val_mem[i_flex_idx] <= i_flex_value;
                end
            end
            // mask table
            always @(posedge i_clk) begin
                if (i_rst) begin
                    mask_q <= 128'h0;
                end else if (wr) begin
                    mask_q[i_flex_idx] <= i_flex_mask;
                end
            end
            // per frame fail and pass
            always @(posedge i_clk) begin
                if (i_rst || frame_end) begin
                    fail_q <= 1'b0;
                    hit_q <= 1'b0;
                end else begin
                    fail_q <= fail_d;
                    hit_q <= flex_hit_d[gf];
                end
            end
        end
    endgenerate
    ////////////////////////////////////////////////////////////////
    // combined wakeup and per-filter flags
    wire [NFLEX+1:0] hits_d;
    assign hits_d = {flex_hit_d, v6_hit_d, v4_hit_d};
    assign keep_now = |hits_d;
    // flags and wake pulse taken at the end of each frame
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_wake <= 1'b0;
            o_wake_status <= `WPF_STATUS_RST;
        end else begin
            o_wake <= frame_end & keep_now & i_power_event_enable;
            if (frame_end) begin
                o_wake_status <= hits_d;
            end
        end
    end

endmodule // wpf_filters

// ==== core/wpf_skid_buf.v ====
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps

module wpf_skid_buf #(
    parameter W = 10
) (
    input wire i_clk, // core clock
    input wire i_rst, // synchronous reset, active high
    input wire i_in_valid, // word offered
    input wire [W-1:0] i_in_data, // word offered
    output wire o_in_ready, // room for a word
    output wire o_out_valid, // word available
    output wire [W-1:0] o_out_data, // oldest word
    input wire i_out_ready // receiver takes the word
);

    reg [W-1:0] mem_q [0:1];
    reg wr_ptr_q;
    reg rd_ptr_q;
    reg [1:0] count_q;
    wire push;
    wire pop;

    // handshakes and honest full/empty
    assign o_in_ready = (count_q != 2'd2);
    assign o_out_valid = (count_q != 2'd0);
    assign o_out_data = mem_q[rd_ptr_q];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    // storage words
    always @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    // pointers and fill count
    always @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            case ({push, pop})
                2'b10: count_q <= count_q + 2'd1;
                2'b01: count_q <= count_q - 2'd1;
                default: count_q <= count_q;
            endcase
        end
    end

endmodule // wpf_skid_buf

// ==== shared/wpf_map.vh ====
// constants for the receive wakeup filters
`ifndef WPF_MAP_VH
`define WPF_MAP_VH

// frame layout, byte positions counted from the first destination byte
`define WPF_MAC_BYTES 8'd6
`define WPF_TYPE_LO_POS 8'd13
`define WPF_VLAN_ID_LO_POS 8'd15
`define WPF_VLAN_LEN 8'd4
`define WPF_SNAP_LEN 8'd8
`define WPF_SNAP_CHK_BYTES 8'd6
`define WPF_SNAP_PATTERN 48'haaaa03000000

// protocol type values
`define WPF_TYPE_VLAN 16'h8100
`define WPF_TYPE_IPV4 16'h0800
`define WPF_TYPE_IPV6 16'h86dd
`define WPF_TYPE_LEN_MAX 16'h05dc

// field offsets relative to the byte after the protocol type
`define WPF_VER_REL 8'h00
`define WPF_VER_IPV4 4'h4
`define WPF_VER_IPV6 4'h6
`define WPF_V4_DIP_REL 8'h10
`define WPF_V4_DIP_LAST 8'h13
`define WPF_V6_DIP_REL 8'h18
`define WPF_V6_DIP_LAST 8'h27

// flexible filter window
`define WPF_FLEX_BYTES 8'h80

// reset values
`define WPF_POS_RST 8'h00
`define WPF_OFF_RST 8'h00
`define WPF_STATUS_RST 6'h00

`endif

// ==== testbench/tb_wpf_filters.sv ====
// self-checking bench for the receive wakeup filters
`timescale 1ns/1ps
module tb_wpf_filters;
////////////////////////////////////////
logic i_clk = 1'b0;
logic i_rst = 1'b1;
wire rx_valid, rx_last, rx_ready, st_valid, st_last, st_keep, wake;
wire [7:0] rx_data, st_data;
wire [5:0] wst;
logic st_ready = 1'b1;
logic v4 = 1'b1, v6 = 1'b1, pe = 1'b1, fwr = 1'b0, fmask = 1'b0, stall = 1'b0, slow = 1'b0;
logic [3:0] fen = 4'h0;
logic vchk = 1'b1;
logic [1:0] fsel = 2'h0;
logic [6:0] fidx = 7'h00;
logic [7:0] fval = 8'h00;
logic [31:0] flen = {4{8'h32}};
logic [47:0] mac = 48'h021122334455;
logic [11:0] vid = 12'h123;
logic [63:0] snap = 64'h0040aaaa03000000;
logic [127:0] v4t = 128'hc0a8010d_c0a8010c_c0a8010b_c0a8010a;
logic [127:0] v6t = 128'hfe800000_00000000_021122ff_fe334455;
int err_count = 0, total_checks = 0, rn, bad, wk, done, p, nf, k, j, cyc = 0;
logic keep;
always #2 i_clk = ~i_clk;
////////////////////////////////////////
wpf_net_model net (.i_clk(i_clk), .i_ready(rx_ready), .o_valid(rx_valid), .o_data(rx_data),
    .o_last(rx_last));
wpf_filters dut (.i_clk(i_clk), .i_rst(i_rst), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_last(rx_last), .o_rx_ready(rx_ready), .o_st_valid(st_valid), .o_st_data(st_data),
    .o_st_last(st_last), .o_st_keep(st_keep), .i_st_ready(st_ready), .i_ipv4_en(v4),
    .i_ipv6_en(v6), .i_flex_en(fen), .i_power_event_enable(pe), .i_station_mac(mac),
    .i_vlan_id_check(vchk), .i_vlan_id(vid), .i_ipv4_addr_table(v4t),
    .i_ipv6_addr_table(v6t), .i_flex_wr(fwr), .i_flex_sel(fsel), .i_flex_idx(fidx),
    .i_flex_mask(fmask), .i_flex_value(fval), .i_flex_length_table(flen), .o_wake(wake),
    .o_wake_status(wst));
// storage side, stalls two cycles of three when asked
always @(negedge i_clk) begin
    cyc <= cyc + 1;
    st_ready <= !stall || (cyc % 3 == 0);
end
// storage stream and wake pulses recorded
always @(posedge i_clk) begin
    if (wake === 1'b1)
        wk++;
    if (st_valid === 1'b1 && st_ready) begin
        if (st_data !== net.fb[rn])
            bad++;
        rn++;
        if (st_last === 1'b1) begin
            keep = st_keep;
            done++;
        end
    end
end
////////////////////////////////////////
task complete_run;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
        err_count++;
        $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
endtask
task fwrite(input int f, input int x, input bit m, input logic [7:0] v);
    @(negedge i_clk);
    fwr = 1'b1;
    fsel = f[1:0];
    fidx = x[6:0];
    fmask = m;
    fval = v;
    @(negedge i_clk);
    fwr = 1'b0;
endtask
task put16(input logic [15:0] w);
    net.fb[p] = w[15:8];
    net.fb[p + 1] = w[7:0];
    p += 2;
endtask
// station address, optional tag and snap, then type
task hdr(input bit vl, input bit sn, input logic [15:0] ty);
    int i;
    for (i = 0; i < 256; i++)
        net.fb[i] = i[7:0] ^ 8'h5c;
    for (i = 0; i < 6; i++)
        net.fb[i] = mac[47 - 8 * i -: 8];
    p = 12;
    if (vl)
        put16(16'h8100);
    if (vl)
        put16({4'h0, vid});
    for (i = 0; i < 4 && sn; i++)
        put16(snap[63 - 16 * i -: 16]);
    put16(ty);
endtask
task ipf(input bit six, input bit vl, input bit sn, input logic [15:0] ty,
    input logic [7:0] ver, input int ent);
    int i;
    hdr(vl, sn, ty);
    net.fb[p] = ver;
    for (i = 0; i < 16; i++)
        if (six)
            net.fb[p + 24 + i] = v6t[127 - 8 * i -: 8];
        else if (i < 4)
            net.fb[p + 16 + i] = v4t[32 * ent + 31 - 8 * i -: 8];
    nf = six ? p + 46 : p + 26;
endtask
// one frame through, then flags, wake, keep and stream
task run(input logic [5:0] es, input logic ew);
    int t;
    rn = 0;
    bad = 0;
    wk = 0;
    done = 0;
    t = 0;
    net.send(nf, slow);
    while (done == 0 && t < 400) begin
        @(negedge i_clk);
        t++;
    end
    repeat (3) @(negedge i_clk);
    if (net.hung || done == 0) begin
        err_count++;
        $display("unexpected frame end: expected seen none");
        complete_run;
    end
    chk("status", {2'h0, es}, {2'h0, wst});
    chk("wake", {7'h0, ew}, wk[7:0]);
    chk("keep", {7'h0, |es}, {7'h0, keep});
    chk("count", nf[7:0], rn[7:0]);
    chk("stream", 8'h00, bad[7:0]);
endtask
////////////////////////////////////////
initial begin
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    for (k = 0; k < 16; k++) begin
        stall = k[3];
        slow = k[0];
        ipf(0, k[2], k[3], 16'h0800, 8'h40 | k[7:0], k % 4);
        run(6'h01, 1);
    end
    for (j = 0; j < 5; j++) begin
        v4 = (j != 0);
        ipf(0, j == 4, 0, j == 1 ? 16'h0806 : 16'h0800, j == 2 ? 8'h55 : 8'h45, 0);
        net.fb[p + 19] ^= {j == 3, 7'h00};
        net.fb[15] ^= {7'h00, j == 4};
        run(6'h00, 0);
    end
    // vlan id mismatch still passes while the id check is off
    vchk = 1'b0;
    ipf(0, 1, 0, 16'h0800, 8'h45, 1);
    net.fb[15] ^= 8'h01;
    run(6'h01, 1);
    vchk = 1'b1;
    v4 = 1'b1;
    for (k = 0; k < 4; k++) begin
        ipf(1, k[0], k[1], 16'h86dd, 8'h6a, 0);
        run(6'h02, 1);
    end
    for (j = 0; j < 4; j++) begin
        v6 = (j != 0);
        ipf(1, 0, 0, j == 1 ? 16'h0800 : 16'h86dd, j == 2 ? 8'h4a : 8'h6a, 0);
        net.fb[p + 39] ^= {7'h00, j == 3};
        run(6'h00, 0);
    end
    pe = 1'b0;
    ipf(0, 0, 0, 16'h0800, 8'h45, 2);
    run(6'h01, 0);
    pe = 1'b1;
    v4 = 1'b0;
    v6 = 1'b0;
    // flexible tables loaded before the enables
    for (k = 0; k < 4; k++) begin
        fwrite(k, 40 + k, 1, 8'ha0 + k[7:0]);
        fwrite(k, 60, 1, 8'h11);
    end
    fen = 4'hf;
    hdr(0, 0, 16'h1234);
    for (k = 0; k < 4; k++)
        net.fb[40 + k] = 8'ha0 + k[7:0];
    nf = 64;
    run(6'h3c, 1);
    net.fb[41] ^= 8'h01;
    run(6'h34, 1);
    net.fb[41] ^= 8'h01;
    nf = 49;
    run(6'h00, 0);
    flen[7:0] = 8'h80;
    fwrite(0, 60, 0, 8'h00);
    fwrite(0, 127, 1, 8'h5a);
    net.fb[127] = 8'h5a;
    nf = 130;
    run(6'h3c, 1);
    fen = 4'h7;
    run(6'h1c, 1);
    net.fb[127] = 8'h00;
    run(6'h18, 1);
    complete_run;
end
endmodule // tb_wpf_filters

// ==== testbench/wpf_filters_monitor.sv ====
// port assertions for the receive wakeup filters
`timescale 1ns/1ps
module wpf_filters_monitor #(
    parameter NFLEX = 4,
    parameter NV4 = 4
) (
    input wire i_clk, // clock
    input wire i_rst, // reset
    input wire i_rx_valid, // byte offered
    input wire i_rx_last, // last byte
    input wire o_rx_ready, // byte taken
    input wire o_st_valid, // storage valid
    input wire [7:0] o_st_data, // storage byte
    input wire o_st_last, // storage last
    input wire i_st_ready, // storage ready
    input wire i_ipv4_en, // ipv4 enable
    input wire i_ipv6_en, // ipv6 enable
    input wire [NFLEX-1:0] i_flex_en, // flex enables
    input wire i_power_event_enable, // wake arm
    input wire o_wake, // wake pulse
    input wire [NFLEX+1:0] o_wake_status // match flags
);
////////////////////////////////////////
// last byte of a frame taken
wire take_last = i_rx_valid && o_rx_ready && i_rx_last;
default clocking cb @(posedge i_clk);
endclocking
default disable iff (i_rst);
////////////////////////////////////////
a_wake_frame_end: assert property (o_wake |-> $past(take_last))
    else $error("wake without frame end");
a_wake_armed: assert property (o_wake |-> $past(i_power_event_enable))
    else $error("wake while not armed");
a_wake_has_flag: assert property (o_wake |-> o_wake_status != 0)
    else $error("wake with no flag");
a_status_at_end: assert property (!$stable(o_wake_status) |-> $past(take_last))
    else $error("status moved mid frame");
a_ipv4_gated: assert property ($past(take_last && !i_ipv4_en) |-> !o_wake_status[0])
    else $error("ipv4 hit while disabled");
a_ipv6_gated: assert property ($past(take_last && !i_ipv6_en) |-> !o_wake_status[1])
    else $error("ipv6 hit while disabled");
a_flex_gated: assert property ($past(take_last) |->
    (o_wake_status[NFLEX+1:2] & ~$past(i_flex_en)) == 0)
    else $error("flex hit while disabled");
a_take_forward: assert property (i_rx_valid && o_rx_ready |=> o_st_valid)
    else $error("taken byte not offered");
a_stall_hold: assert property (o_st_valid && !i_st_ready |=>
    o_st_valid && $stable(o_st_data) && $stable(o_st_last))
    else $error("storage byte changed in stall");
a_full_refuse: assert property (!o_rx_ready |-> o_st_valid ##1 o_st_valid)
    else $error("refused with empty buffer");
endmodule // wpf_filters_monitor
bind wpf_filters wpf_filters_monitor #(.NFLEX(NFLEX), .NV4(NV4)) u_mon (.i_clk(i_clk),
    .i_rst(i_rst), .i_rx_valid(i_rx_valid), .i_rx_last(i_rx_last), .o_rx_ready(o_rx_ready),
    .o_st_valid(o_st_valid), .o_st_data(o_st_data), .o_st_last(o_st_last),
    .i_st_ready(i_st_ready), .i_ipv4_en(i_ipv4_en), .i_ipv6_en(i_ipv6_en),
    .i_flex_en(i_flex_en), .i_power_event_enable(i_power_event_enable), .o_wake(o_wake),
    .o_wake_status(o_wake_status));

// ==== testbench/wpf_net_model.sv ====
// network side model offering received frame bytes
`timescale 1ns/1ps
module wpf_net_model (
    input wire i_clk, // clock
    input wire i_ready, // byte taken
    output logic o_valid, // byte offered
    output logic [7:0] o_data, // frame byte
    output logic o_last // last byte
);
////////////////////////////////////////
logic [7:0] fb [0:255];
logic hung;
// idle lines at time zero
initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_last = 1'b0;
    hung = 1'b0;
end
// bytes held until taken; slow leaves a gap, released data inverted
task send(input int n, input bit slow);
    int i;
    int w;
    for (i = 0; i < n; i++) begin
        @(negedge i_clk);
        o_valid = 1'b1;
        o_data = fb[i];
        o_last = (i == n - 1);
        w = 0;
        while (!i_ready && w < 200) begin
            @(negedge i_clk);
            w++;
        end
        hung = hung | (w >= 200);
        @(posedge i_clk);
        if (slow || i == n - 1) begin
            @(negedge i_clk);
            o_valid = 1'b0;
            o_data = ~o_data;
            o_last = 1'b0;
        end
    end
endtask
endmodule // wpf_net_model
